// ### src/isr_defs.vh
// Constants for the image sensor frame readout block.
// Assumes inclusion by bare name from every design file that needs it.
// Notes on behaviour
// (R1) Left row address selects only the row being read out.
// (R2) Right row address resets rows, apart from the row being read; the code's first rolling reset pulse goes to the start row, the row read first.
// (R3) Snapshot with multiple slopes: whole array reset at once, lowered level.
// (R4) Rolling shutter: right address is a reset pointer, one row at a time.
// (R5) Snapshot: exposure must end before row readout of the frame begins.
// (R6) Each row starts with a blanking interval of typically 3.5 us.
// (R7) One pixel per master clock period.
// (R8) Rolling frame period is rows times blanking plus row pixel time.
// (R9) Snapshot frame period is integration time plus full readout time.
// (R10) Pixel (0,0) green on green-blue row; green1 blue-green, green2 green-red.
// (R11) Row and column start and stop shrink the window down to 2x1.
// (R12) Sub-sampling lowers resolution, keeps field of view, raises frame rate.
// (R13) Controller makes integration and sync signals; sequencer makes the rest.
// (R14) Each pixel sample is a 10-bit word in a continuous stream.
// (R15) Full array is 1280 columns by 1024 rows.
// (R16) Controller supplies one master clock of at most 40 MHz; ISR_CLK_PERIOD_NS of 10 and the bench give 100 MHz.
// (R17) Pixel output rate equals the system clock frequency.
// (R18) Column window start must be even; any row may start.
// (R19) Controller bounds integration with shutter begin and end signals.
// (R20) Controller loads window before frame start and holds it stable.
// (R21) Line valid spans exactly the programmed pixels after blanking ends; the code also holds it high while a full FIFO stalls the row.
`ifndef ISR_DEFS_VH
`define ISR_DEFS_VH

`define ISR_COLS 1280
`define ISR_ROWS 1024
`define ISR_ROW_W 10
`define ISR_COL_W 11
`define ISR_POS_W 12
`define ISR_SAMPLE_W 10
`define ISR_CLR_W 2
`define ISR_FIFO_DEPTH 32
`define ISR_CLK_PERIOD_NS 10
`define ISR_BLANK_NS 3500
`define ISR_BLANK_CNT_W 12

// Colour codes
`define ISR_CLR_GREEN1 2'h0
`define ISR_CLR_BLUE 2'h1
`define ISR_CLR_RED 2'h2
`define ISR_CLR_GREEN2 2'h3

// Position steps; sub-sampling keeps two of every four
`define ISR_STEP_ONE 12'h001
`define ISR_STEP_SKIP 12'h003

// Sequencer states
`define ISR_ST_IDLE 3'h0
`define ISR_ST_EXPOSE 3'h1
`define ISR_ST_BLANK 3'h2
`define ISR_ST_PIXELS 3'h3

`endif

// ### src/isr_sync.v
// Two flip-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to i_clk; output is a clean level.
`timescale 1ns/1ps
module isr_sync #(
  parameter W = 1
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_ce,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta;
  reg [W-1:0] stable;

  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta <= {W{1'b0}};
      stable <= {W{1'b0}};
    end
    else if (i_ce)
    begin
      meta <= i_async;
      stable <= meta;
    end
  end

  assign o_sync = stable;
endmodule // isr_sync

// ### src/isr_fifo.v
// Synchronous FIFO of flip-flops, valid and ready on both sides.
// Assumes a single clock; DEPTH is a power of two.
`timescale 1ns/1ps
module isr_fifo #(
  parameter W = 13,
  parameter DEPTH = 32
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_ce,
  input wire i_wr_valid,
  output wire o_wr_ready,
  input wire [W-1:0] i_wr_data,
  output wire o_rd_valid,
  input wire i_rd_ready,
  output wire [W-1:0] o_rd_data
);
  localparam AW = $clog2(DEPTH);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire empty;
  wire full;
  wire do_wr;
  wire do_rd;

  assign empty = (wr_ptr == rd_ptr);
  // Extra pointer bit tells full from empty
  assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
                (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign o_wr_ready = !full;
  assign o_rd_valid = !empty;
  assign do_wr = i_ce && i_wr_valid && !full;
  assign do_rd = i_ce && i_rd_ready && !empty;
  assign o_rd_data = mem[rd_ptr[AW-1:0]];

  always @(posedge i_clk)
  begin
    if (do_wr)
      mem[wr_ptr[AW-1:0]] <= i_wr_data;
  end

  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // isr_fifo

// ### src/isr_frame_readout.v
// Frame readout sequencer: row addressing, blanking, pixel stream.
// Assumes window and mode inputs come from logic on i_clk and stay
// stable while a frame runs; sync and shutter inputs come from pins.
`timescale 1ns/1ps
`include "isr_defs.vh"
module isr_frame_readout #(
  parameter COLS = `ISR_COLS,
  parameter ROWS = `ISR_ROWS,
  parameter ROW_W = `ISR_ROW_W,
  parameter COL_W = `ISR_COL_W,
  parameter SAMPLE_W = `ISR_SAMPLE_W,
  parameter FIFO_DEPTH = `ISR_FIFO_DEPTH,
  parameter BLANK_NS = `ISR_BLANK_NS,
  parameter CLK_NS = `ISR_CLK_PERIOD_NS
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_ce,
  input wire i_frame_sync,
  input wire i_shutter_begin,
  input wire i_shutter_end,
  input wire i_snapshot_mode,
  input wire i_multi_slope,
  input wire i_subsample,
  input wire [ROW_W-1:0] i_row_start,
  input wire [ROW_W-1:0] i_row_stop,
  input wire [COL_W-1:0] i_col_start,
  input wire [COL_W-1:0] i_col_stop,
  input wire [ROW_W-1:0] i_reset_lag,
  input wire [SAMPLE_W-1:0] i_adc_sample,
  input wire i_pix_ready,
  output wire o_pix_valid,
  output wire [SAMPLE_W-1:0] o_pix_data,
  output wire [`ISR_CLR_W-1:0] o_pix_color,
  output wire o_pix_eol,
  output wire [ROW_W-1:0] o_read_row,
  output wire [ROW_W-1:0] o_reset_row,
  output wire o_reset_row_pulse,
  output wire o_global_reset,
  output wire o_reset_level_low,
  output wire o_pixel_sample,
  output wire [COL_W-1:0] o_col_addr,
  output wire o_blanking,
  output wire o_line_valid,
  output wire o_frame_valid,
  output wire o_exposing
);
  localparam FW = SAMPLE_W + `ISR_CLR_W + 1;
  // Least blanking time: round up to whole cycles
  localparam BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam BLANK_LAST_I = BLANK_CYC - 1;
  localparam [`ISR_BLANK_CNT_W-1:0] BLANK_LAST =
    BLANK_LAST_I[`ISR_BLANK_CNT_W-1:0];
  // Highest address of the array; larger stops are clipped to it
  localparam ROW_LAST_I = ROWS - 1;
  localparam COL_LAST_I = COLS - 1;
  localparam [ROW_W-1:0] ROW_LAST = ROW_LAST_I[ROW_W-1:0];
  localparam [COL_W-1:0] COL_LAST = COL_LAST_I[COL_W-1:0];

  // Next position in a window; sub-sampling skips pairs so Bayer
  // quads stay whole while the field of view is kept
  function [`ISR_POS_W-1:0] isr_step;
    input [`ISR_POS_W-1:0] pos;
    input [`ISR_POS_W-1:0] start;
    input sub;
    reg [`ISR_POS_W-1:0] rel;
    begin
      rel = pos - start;
      if (sub && rel[0])
        isr_step = pos + `ISR_STEP_SKIP;
      else
        isr_step = pos + `ISR_STEP_ONE;
    end
  endfunction

  function [`ISR_CLR_W-1:0] isr_bayer;
    input row_odd;
    input col_odd;
    begin
      if (!row_odd && !col_odd)
        isr_bayer = `ISR_CLR_GREEN1;
      else if (!row_odd)
        isr_bayer = `ISR_CLR_BLUE;
      else if (!col_odd)
        isr_bayer = `ISR_CLR_RED;
      else
        isr_bayer = `ISR_CLR_GREEN2;
    end
  endfunction

  wire frame_lvl;
  wire begin_lvl;
  wire end_lvl;
  reg frame_d;
  reg begin_d;
  reg end_d;
  wire frame_rise;
  wire begin_rise;
  wire end_rise;

  reg [2:0] state;
  reg [`ISR_BLANK_CNT_W-1:0] blank_cnt;
  reg [ROW_W-1:0] row;
  reg [COL_W-1:0] col;
  reg [ROW_W-1:0] reset_row;
  reg reset_pulse;
  reg global_reset;
  reg level_low;
  reg sample_pulse;
  reg frame_valid;
  reg win_sub;
  reg win_snap;
  reg [ROW_W-1:0] win_row_start;
  reg [ROW_W-1:0] win_row_stop;
  reg [COL_W-1:0] win_col_start;
  reg [COL_W-1:0] win_col_stop;
  reg [ROW_W-1:0] win_lag;

  wire [`ISR_POS_W-1:0] next_row;
  wire [`ISR_POS_W-1:0] next_col;
  wire last_row;
  wire last_col;
  wire [`ISR_POS_W-1:0] ptr_sum;
  wire [`ISR_POS_W-1:0] ptr_span;
  wire [ROW_W-1:0] next_reset_row;
  wire fifo_in_ready;
  wire fifo_wr;
  wire [FW-1:0] fifo_in;
  wire [FW-1:0] fifo_out;

  isr_sync #(
    .W(3)
  ) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_async({i_frame_sync, i_shutter_begin, i_shutter_end}),
    .o_sync({frame_lvl, begin_lvl, end_lvl})
  );

  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      frame_d <= 1'b0;
      begin_d <= 1'b0;
      end_d <= 1'b0;
    end
    else if (i_ce)
    begin
      frame_d <= frame_lvl;
      begin_d <= begin_lvl;
      end_d <= end_lvl;
    end
  end

  assign frame_rise = frame_lvl && !frame_d;
  assign begin_rise = begin_lvl && !begin_d;
  assign end_rise = end_lvl && !end_d;

  assign next_row = isr_step({{(`ISR_POS_W-ROW_W){1'b0}}, row},
    {{(`ISR_POS_W-ROW_W){1'b0}}, win_row_start}, win_sub); // R12
  assign next_col = isr_step({{(`ISR_POS_W-COL_W){1'b0}}, col},
    {{(`ISR_POS_W-COL_W){1'b0}}, win_col_start}, win_sub); // R12
  // Stop compares are inclusive, so start equal to stop gives one
  assign last_row = (next_row > {{(`ISR_POS_W-ROW_W){1'b0}},
    win_row_stop}); // R11
  assign last_col = (next_col > {{(`ISR_POS_W-COL_W){1'b0}},
    win_col_stop}); // R11

  // Rolling reset pointer runs a lag ahead, wrapping in the window
  assign ptr_sum = {{(`ISR_POS_W-ROW_W){1'b0}}, next_row[ROW_W-1:0]} +
    {{(`ISR_POS_W-ROW_W){1'b0}}, win_lag};
  assign ptr_span = {{(`ISR_POS_W-ROW_W){1'b0}}, win_row_stop} -
    {{(`ISR_POS_W-ROW_W){1'b0}}, win_row_start} + `ISR_STEP_ONE;
  assign next_reset_row = (ptr_sum > {{(`ISR_POS_W-ROW_W){1'b0}},
    win_row_stop}) ? ptr_sum[ROW_W-1:0] - ptr_span[ROW_W-1:0] :
    ptr_sum[ROW_W-1:0]; // R4

  assign fifo_wr = (state == `ISR_ST_PIXELS); // R7 R17
  assign fifo_in = {last_col, isr_bayer(row[0], col[0]),
    i_adc_sample}; // R10 R14

  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state <= `ISR_ST_IDLE;
      blank_cnt <= {`ISR_BLANK_CNT_W{1'b0}};
      row <= {ROW_W{1'b0}};
      col <= {COL_W{1'b0}};
      reset_row <= {ROW_W{1'b0}};
      reset_pulse <= 1'b0;
      global_reset <= 1'b0;
      level_low <= 1'b0;
      sample_pulse <= 1'b0;
      frame_valid <= 1'b0;
      win_sub <= 1'b0;
      win_snap <= 1'b0;
      win_row_start <= {ROW_W{1'b0}};
      win_row_stop <= {ROW_W{1'b0}};
      win_col_start <= {COL_W{1'b0}};
      win_col_stop <= {COL_W{1'b0}};
      win_lag <= {ROW_W{1'b0}};
    end
    else if (i_ce)
    begin
      reset_pulse <= 1'b0;
      global_reset <= 1'b0;
      sample_pulse <= 1'b0;
      case (state)
        `ISR_ST_IDLE:
        begin
          level_low <= 1'b0;
          // Window is taken once per frame; later edits wait a frame
          win_sub <= i_subsample;
          win_snap <= i_snapshot_mode;
          win_row_start <= i_row_start;
          win_row_stop <= (i_row_stop > ROW_LAST) ? ROW_LAST :
            i_row_stop; // R15
          // Odd column starts are rounded down to keep colour pairs
          win_col_start <= {i_col_start[COL_W-1:1], 1'b0}; // R18
          win_col_stop <= (i_col_stop > COL_LAST) ? COL_LAST :
            i_col_stop; // R15
          win_lag <= i_reset_lag;
          if (i_snapshot_mode && begin_rise)
          begin
            // Whole array reset at the start of exposure
            state <= `ISR_ST_EXPOSE;
            global_reset <= 1'b1; // R2 R3
            level_low <= i_multi_slope; // R3
            frame_valid <= 1'b1;
          end
          else if (!i_snapshot_mode && frame_rise)
          begin
            state <= `ISR_ST_BLANK;
            row <= i_row_start;
            reset_row <= i_row_start;
            reset_pulse <= 1'b1; // R4
            blank_cnt <= {`ISR_BLANK_CNT_W{1'b0}};
            frame_valid <= 1'b1;
          end
        end
        `ISR_ST_EXPOSE:
        begin
          // Frame sync is ignored here; readout waits for exposure end
          if (end_rise)
          begin
            state <= `ISR_ST_BLANK; // R5 R9
            sample_pulse <= 1'b1;
            level_low <= 1'b0;
            row <= win_row_start;
            blank_cnt <= {`ISR_BLANK_CNT_W{1'b0}};
          end
        end
        `ISR_ST_BLANK:
        begin
          if (blank_cnt == BLANK_LAST)
          begin
            state <= `ISR_ST_PIXELS; // R6
            col <= win_col_start;
          end
          else
            blank_cnt <= blank_cnt + 1'b1; // R6
        end
        `ISR_ST_PIXELS:
        begin
          // A full FIFO stalls the column pointer, so no pixel is lost
          if (fifo_in_ready)
          begin
            if (!last_col)
              col <= next_col[COL_W-1:0]; // R7
            else if (last_row)
            begin
              state <= `ISR_ST_IDLE; // R8
              frame_valid <= 1'b0;
            end
            else
            begin
              state <= `ISR_ST_BLANK; // R8
              row <= next_row[ROW_W-1:0]; // R1
              blank_cnt <= {`ISR_BLANK_CNT_W{1'b0}};
              if (!win_snap)
              begin
                reset_row <= next_reset_row; // R2 R4
                reset_pulse <= 1'b1; // R4
              end
            end
          end
        end
        default:
        begin
          state <= `ISR_ST_IDLE;
          frame_valid <= 1'b0;
        end
      endcase
    end
  end

  isr_fifo #(
    .W(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_wr_valid(fifo_wr),
    .o_wr_ready(fifo_in_ready),
    .i_wr_data(fifo_in),
    .o_rd_valid(o_pix_valid),
    .i_rd_ready(i_pix_ready),
    .o_rd_data(fifo_out)
  );

  assign o_pix_data = fifo_out[SAMPLE_W-1:0]; // R14
  assign o_pix_color = fifo_out[SAMPLE_W+`ISR_CLR_W-1:SAMPLE_W]; // R10
  assign o_pix_eol = fifo_out[FW-1];
  assign o_read_row = row; // R1
  assign o_reset_row = reset_row; // R2
  assign o_reset_row_pulse = reset_pulse;
  assign o_global_reset = global_reset;
  assign o_reset_level_low = level_low;
  assign o_pixel_sample = sample_pulse;
  assign o_col_addr = col;
  assign o_blanking = (state == `ISR_ST_BLANK);
  assign o_line_valid = (state == `ISR_ST_PIXELS); // R21
  assign o_frame_valid = frame_valid;
  assign o_exposing = (state == `ISR_ST_EXPOSE);
endmodule // isr_frame_readout

// ### tb/isr_checker.sv
// Port-level assertions for the frame readout sequencer.
// Assumes binding to isr_frame_readout; one clock domain.
`timescale 1ns/1ps
module isr_checker #(
  parameter BLANK_NS = 3500,
  parameter CLK_NS = 10
) (
  input logic i_clk,
  input logic i_rstn,
  input logic i_ce,
  input logic i_pix_ready,
  input logic o_pix_valid,
  input logic [9:0] o_pix_data,
  input logic [9:0] o_read_row,
  input logic o_reset_row_pulse,
  input logic o_global_reset,
  input logic o_reset_level_low,
  input logic o_pixel_sample,
  input logic o_blanking,
  input logic o_line_valid,
  input logic o_exposing
);
  localparam int BLK = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  int n_blk;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // Blanking can run to hundreds of cycles, too long to unroll
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      n_blk <= 0;
    else
      // Frozen cycles do not advance the blanking counter
      n_blk <= !o_blanking ? 0 : (i_ce ? n_blk + 1 : n_blk);
  sequence s_blank_end;
    $fell(o_blanking);
  endsequence
  sequence s_stall;
    o_pix_valid && !i_pix_ready;
  endsequence
  blank_len_a: assert property (s_blank_end |-> n_blk == BLK)
    else $error("row blanking length wrong");
  line_start_a: assert property (s_blank_end |-> o_line_valid)
    else $error("pixels do not follow blanking");
  row_hold_a: assert property (o_line_valid && $past(o_line_valid)
    |-> $stable(o_read_row))
    else $error("read row moved within a row");
  reset_ptr_a: assert property (o_reset_row_pulse
    |-> o_blanking && !o_exposing ##1 !o_reset_row_pulse)
    else $error("row reset pulse misplaced");
  global_pulse_a: assert property (o_global_reset
    |-> o_exposing ##1 !o_global_reset)
    else $error("array reset pulse wrong");
  low_level_a: assert property (o_reset_level_low |-> o_exposing)
    else $error("lowered reset outside exposure");
  no_overlap_a: assert property (o_exposing
    |-> !o_line_valid && !o_blanking)
    else $error("readout during exposure");
  sample_read_a: assert property (o_pixel_sample
    |-> $past(o_exposing) && o_blanking ##1 !o_pixel_sample)
    else $error("readout not right after exposure");
  stream_hold_a: assert property (s_stall
    |=> o_pix_valid && $stable(o_pix_data))
    else $error("stream word dropped while stalled");
endmodule // isr_checker

bind isr_frame_readout isr_checker #(
  .BLANK_NS(BLANK_NS),
  .CLK_NS(CLK_NS)
) i_chk (
  .i_clk(i_clk),
  .i_rstn(i_rstn),
  .i_ce(i_ce),
  .i_pix_ready(i_pix_ready),
  .o_pix_valid(o_pix_valid),
  .o_pix_data(o_pix_data),
  .o_read_row(o_read_row),
  .o_reset_row_pulse(o_reset_row_pulse),
  .o_global_reset(o_global_reset),
  .o_reset_level_low(o_reset_level_low),
  .o_pixel_sample(o_pixel_sample),
  .o_blanking(o_blanking),
  .o_line_valid(o_line_valid),
  .o_exposing(o_exposing)
);

// ### tb/isr_ctrl_model.sv
// Camera controller model: sync and shutter pins, converter, sink.
// Assumes pins are seen after two sync flops; tb sets stall.
`timescale 1ns/1ps
module isr_ctrl_model (
  input logic i_clk,
  input logic i_pix_valid,
  input logic [9:0] i_pix_data,
  input logic [1:0] i_pix_color,
  input logic i_pix_eol,
  input logic [9:0] i_row,
  input logic [10:0] i_col,
  output logic o_frame_sync,
  output logic o_shutter_begin,
  output logic o_shutter_end,
  output logic [9:0] o_adc_sample,
  output logic o_pix_ready
);
  logic stall = 1'b0;
  logic [12:0] rx_q[$];
  initial
  begin
    {o_shutter_end, o_shutter_begin, o_frame_sync} = 3'b000;
  end
  // Converter word names its pixel, so misplaced words show up
  assign o_adc_sample = {i_row[4:0], i_col[4:0]};
  // Held four cycles so the synchroniser cannot miss it
  task automatic pin(input int k);
    @(posedge i_clk);
    #1;
    {o_shutter_end, o_shutter_begin, o_frame_sync} = 3'b001 << k;
    repeat (4) @(posedge i_clk);
    #1;
    {o_shutter_end, o_shutter_begin, o_frame_sync} = 3'b000;
  endtask
  assign o_pix_ready = !stall;
  always @(posedge i_clk)
    if (i_pix_valid && o_pix_ready)
      rx_q.push_back({i_pix_eol, i_pix_color, i_pix_data});
endmodule // isr_ctrl_model

// ### tb/tb.sv
// Self-checking bench for isr_frame_readout with controller model.
// Assumes a 100 MHz clock; blanking shortened to 5 cycles.
`timescale 1ns/1ps
module tb;
  localparam int BLK = 5;
  logic i_clk, i_rstn, snap, mslope, sub, clk_en;
  logic [9:0] rs, re, lag;
  logic [10:0] cs, ce;
  wire fs, sb, se, rdy, pv, eol, rrp, gr, ps, bl, lv, fv, lowlv, expo;
  wire [9:0] adc, pd, rrow, rst_row;
  wire [10:0] col;
  wire [1:0] clr;
  int bad_count = 0, n_compared = 0, cyc = 0;
  int fv_len, rp_cnt, gr_cnt, ps_cnt, len, nr, nc, lr;
  isr_frame_readout #(.BLANK_NS(50), .CLK_NS(10)) i_isr_frame_readout (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(clk_en),
    .i_frame_sync(fs), .i_shutter_begin(sb), .i_shutter_end(se),
    .i_snapshot_mode(snap), .i_multi_slope(mslope), .i_subsample(sub),
    .i_row_start(rs), .i_row_stop(re), .i_col_start(cs),
    .i_col_stop(ce), .i_reset_lag(lag), .i_adc_sample(adc),
    .i_pix_ready(rdy), .o_pix_valid(pv), .o_pix_data(pd),
    .o_pix_color(clr), .o_pix_eol(eol), .o_read_row(rrow),
    .o_reset_row(rst_row), .o_reset_row_pulse(rrp), .o_global_reset(gr),
    .o_reset_level_low(lowlv), .o_pixel_sample(ps), .o_col_addr(col),
    .o_blanking(bl), .o_line_valid(lv), .o_frame_valid(fv),
    .o_exposing(expo));
  isr_ctrl_model i_isr_ctrl_model (
    .i_clk(i_clk), .i_pix_valid(pv), .i_pix_data(pd),
    .i_row(rrow), .i_col(col),
    .i_pix_color(clr), .i_pix_eol(eol), .o_frame_sync(fs),
    .o_shutter_begin(sb), .o_shutter_end(se), .o_adc_sample(adc),
    .o_pix_ready(rdy));
  initial
  begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    fv_len += fv;
    rp_cnt += rrp;
    gr_cnt += gr;
    ps_cnt += ps;
    cyc++;
    // Whole run needs well under this
    if (cyc == 20000)
    begin
      bad_count++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] got, exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // Window stays fixed for the whole frame
  task automatic cfg(input logic s, m, u, input int a, b, c, d);
    @(posedge i_clk);
    #1;
    {snap, mslope, sub} = {s, m, u};
    rs = a;
    re = b;
    cs = c;
    ce = d;
    {fv_len, rp_cnt, gr_cnt, ps_cnt} = 0;
  endtask
  task automatic finish_frame();
    int w;
    w = 0;
    while ((fv || pv) && w < 3000)
    begin
      @(posedge i_clk);
      w++;
    end
    #1;
  endtask
  // Pops every word of the window and checks order, colour and end flag
  task automatic check_rx(output int nr, nc);
    logic [12:0] wd;
    int r, c, cn, tr, tc;
    nr = 0;
    r = rs;
    tr = 0;
    while (r <= re)
    begin
      nr++;
      lr = r;
      nc = 0;
      c = cs;
      tc = 0;
      while (c <= ce)
      begin
        nc++;
        cn = c + ((sub && tc) ? 3 : 1);
        wd = i_isr_ctrl_model.rx_q.size() ?
          i_isr_ctrl_model.rx_q.pop_front() : 13'h1fff;
        chk(wd, {cn > ce, r[0], c[0], r[4:0], c[4:0]}, "word");
        c = cn;
        tc = !tc;
      end
      r += (sub && tr) ? 3 : 1;
      tr = !tr;
    end
    chk(i_isr_ctrl_model.rx_q.size(), 0, "extra words");
  endtask
  task automatic t_roll(input int a, b, c, d, u, g, input string nm);
    lag = g;
    cfg(0, 0, u, a, b, c, d);
    i_isr_ctrl_model.pin(0);
    finish_frame();
    len = fv_len;
    check_rx(nr, nc);
    chk(len, nr * (BLK + nc), "frame length");
    chk(rp_cnt, nr, "row resets");
    chk(gr_cnt, 0, "array reset");
    chk(rrow, lr, "read row");
    chk(rst_row, (lr - a + g) % (b - a + 1) + a, "reset pointer");
    $display("test %s done", nm);
  endtask
  // Freeze in first row blanking, while the buffer is empty
  task automatic t_freeze();
    cfg(0, 0, 0, 2, 3, 4, 7);
    i_isr_ctrl_model.pin(0);
    clk_en = 0;
    repeat (8) @(posedge i_clk);
    #1;
    chk({bl, rrp, pv, lv}, 4'b1000, "frozen blanking");
    clk_en = 1;
    finish_frame();
    len = fv_len;
    check_rx(nr, nc);
    chk(len, nr * (BLK + nc) + 8, "frozen frame length");
    $display("test freeze done");
  endtask
  task automatic t_stall();
    cfg(0, 0, 0, 0, 0, 0, 39);
    i_isr_ctrl_model.stall = 1;
    i_isr_ctrl_model.pin(0);
    repeat (60) @(posedge i_clk);
    #1;
    chk({pv, lv}, 2'b11, "full buffer holds row");
    i_isr_ctrl_model.stall = 0;
    finish_frame();
    chk(fv_len > BLK + 40, 1, "stall lengthens row");
    check_rx(nr, nc);
    $display("test stall done");
  endtask
  task automatic t_snap();
    cfg(1, 1, 0, 1, 1, 2, 3);
    i_isr_ctrl_model.pin(1);
    repeat (3) @(posedge i_clk);
    #1;
    chk(expo, 1, "exposing");
    chk(lowlv, 1, "low level");
    i_isr_ctrl_model.pin(0);
    repeat (5) @(posedge i_clk);
    #1;
    chk({lv, bl}, 2'b00, "sync ignored in exposure");
    i_isr_ctrl_model.pin(2);
    finish_frame();
    chk(gr_cnt, 1, "array reset");
    chk(ps_cnt, 1, "sample pulse");
    chk(rp_cnt, 0, "row resets");
    check_rx(nr, nc);
    chk({rrow, lowlv}, {lr[9:0], 1'b0}, "row and level after");
    $display("test snapshot done");
  endtask
  initial
  begin
    {snap, mslope, sub} = 3'b000;
    {rs, re, cs, ce} = 0;
    lag = 10'h001;
    clk_en = 1;
    i_rstn = 0;
    repeat (6) @(posedge i_clk);
    #1;
    i_rstn = 1;
    chk({pv, fv, lv, bl}, 4'h0, "idle after reset");
    t_roll(2, 3, 4, 7, 0, 1, "rolling");
    t_roll(5, 5, 6, 7, 0, 2, "smallest window");
    t_roll(0, 3, 0, 7, 1, 3, "subsample");
    t_freeze();
    t_stall();
    t_snap();
    conclude();
  end
endmodule // tb
